// ### hw/harvester_cfg_pkg.sv
// Shared constants of the harvester configuration register bank
package harvester_cfg_pkg;

	// ----------------------------------------------------------------
	// Serial target address and register offsets
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h41;
	localparam logic [7:0] OFS_VERSION = 8'h00;
	localparam logic [7:0] OFS_SRC = 8'h01;
	localparam logic [7:0] OFS_OVDIS = 8'h02;
	localparam logic [7:0] OFS_OVCH = 8'h03;
	localparam logic [7:0] OFS_COLD = 8'h04;
	localparam logic [7:0] OFS_HOT = 8'h05;
	localparam logic [7:0] OFS_PWR = 8'h06;
	localparam logic [7:0] OFS_SLEEP = 8'h07;
	localparam logic [7:0] OFS_RESERVED_SINK = 8'h08;
	localparam logic [7:0] OFS_METER = 8'h09;
	localparam logic [7:0] OFS_EN = 8'h0A;
	localparam logic [7:0] OFS_CTRL = 8'h0B;
	localparam logic [7:0] OFS_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h0D;
	localparam logic [7:0] OFS_MDATA0 = 8'h0E;
	localparam logic [7:0] OFS_MDATA1 = 8'h0F;
	localparam logic [7:0] OFS_MDATA2 = 8'h10;
	localparam logic [7:0] OFS_TEMP = 8'h11;
	localparam logic [7:0] OFS_STO = 8'h12;
	localparam logic [7:0] OFS_PART0 = 8'hE0;
	localparam logic [7:0] OFS_PART1 = 8'hE1;
	localparam logic [7:0] OFS_PART2 = 8'hE2;
	localparam logic [7:0] OFS_PART3 = 8'hE3;
	localparam logic [7:0] OFS_PART4 = 8'hE4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] RST_SRC = 7'h77;
	localparam logic [5:0] RST_OVDIS = 6'h2D;
	localparam logic [5:0] RST_OVCH = 6'h33;
	localparam logic [7:0] RST_COLD = 8'h8F;
	localparam logic [7:0] RST_HOT = 8'h2F;
	localparam logic [3:0] RST_PWR = 4'h7;
	localparam logic [3:0] RST_SLEEP = 4'h1;
	localparam logic [5:0] RST_EN = 6'h01;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PWR_HOLD = 0;
	localparam int PWR_HIGH = 1;
	localparam int PWR_THERM = 2;
	localparam int PWR_INHIBIT = 3;
	localparam int CTRL_UPDATE = 0;
	localparam int CTRL_BUSY = 2;
	localparam int EV_READY = 0;
	localparam int EV_DONE = 5;
	localparam int EV_ERR = 6;
	localparam int ST_CHARGE = 6;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int LOAD_TIME_NS = 32;
	localparam int LOAD_CYCLES = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] BOOT_CAPTURE = 2'h2;
	localparam logic [1:0] BOOT_DONE = 2'h3;

endpackage

// ### hw/harvester_config_registers.sv
// Serial-target register bank of the harvester charger controller
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Decode source strap to regulation voltage
// - Decode storage strap to threshold pair
// - Source regulation register, reset 0x77
// - Overdischarge threshold register, reset 0x2D
// - Overcharge threshold register, reset 0x33
// - Cold limit register, reset 0x8F
// - Hot limit register, reset 0x2F
// - Power control bits with given resets
// - Reserved register writable, no effect
// - Update bit loads serial configuration
// - Busy flag while configuration transfers
// - Event enables, serial-ready set, bit6 fixed
// - Event flags at enable positions
// - Five fixed part identification bytes
// - Answer at target address 0x41
// - After serial load, straps ignored
// - Startup config from straps, float high
// - Inhibit and hold-up pins float low
module harvester_config_registers #(
	parameter logic [7:0] VERSION_ID = 8'h01,
	parameter logic [39:0] PART_ID = 40'h5A5B5C5D5E // arbitrary value
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_b,
	output logic irq,
	input wire logic [5:0] source_level_strap,
	input wire logic [2:0] storage_threshold_strap,
	input wire logic charge_inhibit_input,
	input wire logic hold_up_input,
	input wire logic [3:0] condition_pins,
	input wire logic charging_pin,
	input wire logic meter_done_event,
	input wire logic meter_error_event,
	input wire logic [23:0] meter_data,
	input wire logic [7:0] temperature_data,
	input wire logic [7:0] storage_data,
	output logic serial_cfg_active,
	output logic [6:0] strap_src_cv,
	output logic [8:0] strap_ovch_cv,
	output logic [8:0] strap_ovdis_cv,
	output logic [6:0] source_regulation_value,
	output logic [5:0] overdischarge_limit,
	output logic [5:0] overcharge_limit,
	output logic [7:0] cold_limit_value,
	output logic [7:0] hot_limit_value,
	output logic hold_up_enable,
	output logic high_power_enable,
	output logic thermal_watch_enable,
	output logic charge_inhibit,
	output logic sleep_enable,
	output logic [2:0] sleep_threshold,
	output logic power_meter_enable
);
	typedef enum logic [2:0] {IDLE, ADDR, ACK_ADDR, WRITE, ACK_W, READ, RACK} bus_st_t;

	typedef struct packed {
		logic scl_m, scl_s, scl_q;
		logic sda_m, sda_s, sda_q;
		logic [4:0] sts_m, sts_s, sts_q;
		logic [5:0] src_m, src_s;
		logic [2:0] sto_m, sto_s;
		logic hold_m, hold_s, inh_m, inh_s;
		logic [1:0] boot_cnt;
		logic [5:0] src_code;
		logic [2:0] sto_code;
		bus_st_t st;
		logic [3:0] cnt;
		logic [7:0] sh, ptr;
		logic first, rw, drv;
		logic [6:0] src;
		logic [5:0] ovdis, ovch;
		logic [7:0] cold, hot;
		logic [3:0] power_control, slp;
		logic [2:0] reserved_sink;
		logic [3:0] meter;
		logic [5:0] en;
		logic [6:0] flags;
		logic busy;
		logic [2:0] bcnt;
		logic serial;
		logic [6:0] a_src;
		logic [5:0] a_ovdis, a_ovch;
		logic [7:0] a_cold, a_hot;
		logic [3:0] a_pwr, a_slp;
		logic a_meter;
	} state_t;

	state_t state_r;
	state_t state_nxt;
	logic [7:0] rd_byte;
	logic reg_wr;
	logic load_rd;
	logic rd_clr;
	logic [6:0] ev;
	logic scl_rise, scl_fall, start_seen, stop_seen;

	strap_if sif ();

	// ----------------------------------------------------------------
	// Strap decoding
	// ----------------------------------------------------------------
	strap_decoder strap_decoder_i (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.sif(sif)
	);

	// Codes held once captured; decoder sees only settled values
	assign sif.src_code = state_r.src_code;
	assign sif.sto_code = state_r.sto_code;
	assign strap_src_cv = sif.src_cv;
	assign strap_ovch_cv = sif.ovch_cv;
	assign strap_ovdis_cv = sif.ovdis_cv;

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	// Unmapped offsets read as zero
	always_comb begin
		case (state_r.ptr)
			harvester_cfg_pkg::OFS_VERSION: rd_byte = VERSION_ID;
			harvester_cfg_pkg::OFS_SRC: rd_byte = {1'b0, state_r.src};
			harvester_cfg_pkg::OFS_OVDIS: rd_byte = {2'h0, state_r.ovdis};
			harvester_cfg_pkg::OFS_OVCH: rd_byte = {2'h0, state_r.ovch};
			harvester_cfg_pkg::OFS_COLD: rd_byte = state_r.cold;
			harvester_cfg_pkg::OFS_HOT: rd_byte = state_r.hot;
			harvester_cfg_pkg::OFS_PWR: rd_byte = {4'h0, state_r.power_control};
			harvester_cfg_pkg::OFS_SLEEP: rd_byte = {4'h0, state_r.slp};
			harvester_cfg_pkg::OFS_RESERVED_SINK: rd_byte = {5'h00, state_r.reserved_sink};
			harvester_cfg_pkg::OFS_METER: rd_byte = {4'h0, state_r.meter};
			harvester_cfg_pkg::OFS_EN: rd_byte = {2'h0, state_r.en};
			harvester_cfg_pkg::OFS_CTRL: rd_byte = {5'h00, state_r.busy, 2'h0};
			harvester_cfg_pkg::OFS_FLAGS: rd_byte = {1'b0, state_r.flags};
			harvester_cfg_pkg::OFS_STATUS: rd_byte = {1'b0, state_r.sts_s[4], 1'b0,
				state_r.sts_s[3:0], 1'b0};
			harvester_cfg_pkg::OFS_MDATA0: rd_byte = meter_data[7:0];
			harvester_cfg_pkg::OFS_MDATA1: rd_byte = meter_data[15:8];
			harvester_cfg_pkg::OFS_MDATA2: rd_byte = meter_data[23:16];
			harvester_cfg_pkg::OFS_TEMP: rd_byte = temperature_data;
			harvester_cfg_pkg::OFS_STO: rd_byte = storage_data;
			harvester_cfg_pkg::OFS_PART0: rd_byte = PART_ID[39:32];
			harvester_cfg_pkg::OFS_PART1: rd_byte = PART_ID[31:24];
			harvester_cfg_pkg::OFS_PART2: rd_byte = PART_ID[23:16];
			harvester_cfg_pkg::OFS_PART3: rd_byte = PART_ID[15:8];
			harvester_cfg_pkg::OFS_PART4: rd_byte = PART_ID[7:0];
			default: rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus edge detection on synchronised lines
	// ----------------------------------------------------------------
	// Second flop against its delayed copy; first flop feeds nothing else
	assign scl_rise = state_r.scl_s & ~state_r.scl_q;
	assign scl_fall = ~state_r.scl_s & state_r.scl_q;
	assign start_seen = state_r.scl_s & state_r.scl_q & state_r.sda_q & ~state_r.sda_s;
	assign stop_seen = state_r.scl_s & state_r.scl_q & ~state_r.sda_q & state_r.sda_s;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		reg_wr = 1'b0;
		load_rd = 1'b0;
		rd_clr = 1'b0;
		ev = 7'h00;
		// Two-flop synchronisers for bus, status, strap and mode pins; meter events and data enter unsynchronised
		state_nxt.scl_m = scl_pin;
		state_nxt.scl_s = state_r.scl_m;
		state_nxt.scl_q = state_r.scl_s;
		state_nxt.sda_m = sda_in;
		state_nxt.sda_s = state_r.sda_m;
		state_nxt.sda_q = state_r.sda_s;
		state_nxt.sts_m = {charging_pin, condition_pins};
		state_nxt.sts_s = state_r.sts_m;
		state_nxt.sts_q = state_r.sts_s;
		state_nxt.src_m = source_level_strap;
		state_nxt.src_s = state_r.src_m;
		state_nxt.sto_m = storage_threshold_strap;
		state_nxt.sto_s = state_r.sto_m;
		state_nxt.hold_m = hold_up_input;
		state_nxt.hold_s = state_r.hold_m;
		state_nxt.inh_m = charge_inhibit_input;
		state_nxt.inh_s = state_r.inh_m;

		// Straps caught once, after the synchronisers have filled
		if (state_r.boot_cnt != harvester_cfg_pkg::BOOT_DONE) begin
			state_nxt.boot_cnt = state_r.boot_cnt + 2'h1;
			if (state_r.boot_cnt == harvester_cfg_pkg::BOOT_CAPTURE) begin
				state_nxt.src_code = state_r.src_s;
				state_nxt.sto_code = state_r.sto_s;
			end
		end

		// Mode pins steer only until a serial load
		if (!state_r.serial) begin
			state_nxt.a_pwr[harvester_cfg_pkg::PWR_HOLD] = state_r.hold_s;
			state_nxt.a_pwr[harvester_cfg_pkg::PWR_INHIBIT] = state_r.inh_s;
		end

		// Serial target; start and stop override any state
		if (stop_seen) begin
			state_nxt.st = IDLE;
			state_nxt.drv = 1'b0;
		end else if (start_seen) begin
			state_nxt.st = ADDR;
			state_nxt.cnt = 4'h0;
			state_nxt.drv = 1'b0;
			state_nxt.first = 1'b1;
		end else begin
			unique case (state_r.st)
				IDLE: begin
				end
				ADDR, WRITE: begin
					if (scl_rise && state_r.cnt < 4'h8) begin
						state_nxt.sh = {state_r.sh[6:0], state_r.sda_s};
						state_nxt.cnt = state_r.cnt + 4'h1;
					end
					if (scl_fall && state_r.cnt == 4'h8) begin
						if (state_r.st == WRITE) begin
							state_nxt.drv = 1'b1;
							state_nxt.st = ACK_W;
							if (state_r.first) begin
								state_nxt.ptr = state_r.sh;
								state_nxt.first = 1'b0;
							end else begin
								reg_wr = 1'b1;
								state_nxt.ptr = state_r.ptr + 8'h01;
							end
						end else if (state_r.sh[7:1] == harvester_cfg_pkg::DEV_ADDR) begin
							state_nxt.drv = 1'b1;
							state_nxt.rw = state_r.sh[0];
							state_nxt.st = ACK_ADDR;
						end else begin
							state_nxt.st = IDLE;
						end
					end
				end
				ACK_ADDR: begin
					if (scl_fall) begin
						state_nxt.cnt = 4'h0;
						state_nxt.drv = 1'b0;
						state_nxt.st = WRITE;
						load_rd = state_r.rw;
					end
				end
				ACK_W: begin
					if (scl_fall) begin
						state_nxt.drv = 1'b0;
						state_nxt.cnt = 4'h0;
						state_nxt.st = WRITE;
					end
				end
				READ: begin
					if (scl_rise && state_r.cnt < 4'h8) begin
						state_nxt.cnt = state_r.cnt + 4'h1;
					end
					if (scl_fall && state_r.cnt == 4'h8) begin
						state_nxt.drv = 1'b0;
						state_nxt.st = RACK;
					end else if (scl_fall && state_r.cnt != 4'h0) begin
						state_nxt.sh = {state_r.sh[6:0], 1'b0};
						state_nxt.drv = ~state_r.sh[6];
					end
				end
				RACK: begin
					// Controller's acknowledge decides whether to go on
					if (scl_rise) begin
						if (state_r.sda_s) begin
							state_nxt.st = IDLE;
						end else begin
							state_nxt.cnt = 4'h9;
						end
					end
					if (scl_fall && state_r.cnt == 4'h9) begin
						load_rd = 1'b1;
					end
				end
				default: begin
					state_nxt.st = IDLE;
					state_nxt.drv = 1'b0;
				end
			endcase
		end

		// Byte fetch for a read, pointer steps past it
		if (load_rd) begin
			state_nxt.sh = rd_byte;
			state_nxt.drv = ~rd_byte[7];
			state_nxt.ptr = state_r.ptr + 8'h01;
			state_nxt.cnt = 4'h0;
			state_nxt.st = READ;
			rd_clr = (state_r.ptr == harvester_cfg_pkg::OFS_FLAGS);
		end

		// Register writes; read-only and unmapped offsets drop the data
		if (reg_wr) begin
			case (state_r.ptr)
				harvester_cfg_pkg::OFS_SRC: state_nxt.src = state_r.sh[6:0];
				harvester_cfg_pkg::OFS_OVDIS: state_nxt.ovdis = state_r.sh[5:0];
				harvester_cfg_pkg::OFS_OVCH: state_nxt.ovch = state_r.sh[5:0];
				harvester_cfg_pkg::OFS_COLD: state_nxt.cold = state_r.sh;
				harvester_cfg_pkg::OFS_HOT: state_nxt.hot = state_r.sh;
				harvester_cfg_pkg::OFS_PWR: state_nxt.power_control = state_r.sh[3:0];
				harvester_cfg_pkg::OFS_SLEEP: state_nxt.slp = state_r.sh[3:0];
				harvester_cfg_pkg::OFS_RESERVED_SINK: state_nxt.reserved_sink = state_r.sh[2:0];
				harvester_cfg_pkg::OFS_METER: state_nxt.meter = state_r.sh[3:0];
				harvester_cfg_pkg::OFS_EN: state_nxt.en = state_r.sh[5:0];
				harvester_cfg_pkg::OFS_CTRL: begin
					// A request during a transfer is absorbed by it
					if (state_r.sh[harvester_cfg_pkg::CTRL_UPDATE] && !state_r.busy) begin
						state_nxt.busy = 1'b1;
						state_nxt.bcnt = 3'(harvester_cfg_pkg::LOAD_CYCLES);
					end
				end
				default: begin
				end
			endcase
		end

		// Configuration transfer into the core
		if (state_r.busy) begin
			if (state_r.bcnt == 3'h1) begin
				state_nxt.busy = 1'b0;
				state_nxt.serial = 1'b1;
				state_nxt.a_src = state_r.src;
				state_nxt.a_ovdis = state_r.ovdis;
				state_nxt.a_ovch = state_r.ovch;
				state_nxt.a_cold = state_r.cold;
				state_nxt.a_hot = state_r.hot;
				state_nxt.a_pwr = state_r.power_control;
				state_nxt.a_slp = state_r.slp;
				state_nxt.a_meter = state_r.meter[0];
				ev[harvester_cfg_pkg::EV_READY] = 1'b1;
			end else begin
				state_nxt.bcnt = state_r.bcnt - 3'h1;
			end
		end

		// Events: condition rising edges and meter pulses
		ev[4:1] = state_r.sts_s[3:0] & ~state_r.sts_q[3:0];
		ev[harvester_cfg_pkg::EV_DONE] = meter_done_event;
		ev[harvester_cfg_pkg::EV_ERR] = meter_error_event;
		// New event wins over the clear of a flags read
		state_nxt.flags = (state_r.flags & ~{7{rd_clr}}) | ev;

		if (!rst_b) begin
			state_nxt = '0;
			state_nxt.src = harvester_cfg_pkg::RST_SRC;
			state_nxt.ovdis = harvester_cfg_pkg::RST_OVDIS;
			state_nxt.ovch = harvester_cfg_pkg::RST_OVCH;
			state_nxt.cold = harvester_cfg_pkg::RST_COLD;
			state_nxt.hot = harvester_cfg_pkg::RST_HOT;
			state_nxt.power_control = harvester_cfg_pkg::RST_PWR;
			state_nxt.slp = harvester_cfg_pkg::RST_SLEEP;
			state_nxt.en = harvester_cfg_pkg::RST_EN;
			state_nxt.a_src = state_nxt.src;
			state_nxt.a_ovdis = state_nxt.ovdis;
			state_nxt.a_ovch = state_nxt.ovch;
			state_nxt.a_cold = state_nxt.cold;
			state_nxt.a_hot = state_nxt.hot;
			state_nxt.a_pwr = state_nxt.power_control;
			state_nxt.a_slp = state_nxt.slp;
			state_nxt.src_code = 6'h3F;
			state_nxt.sto_code = 3'h7;
			state_nxt.scl_m = 1'b1;
			state_nxt.scl_s = 1'b1;
			state_nxt.scl_q = 1'b1;
			state_nxt.sda_m = 1'b1;
			state_nxt.sda_s = 1'b1;
			state_nxt.sda_q = 1'b1;
		end
	end

	// Single state register
	always_ff @(posedge core_clk) begin
		state_r <= state_nxt;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe_b = ~state_r.drv;
	assign irq = |(state_r.flags[5:0] & state_r.en);
	assign serial_cfg_active = state_r.serial;
	assign source_regulation_value = state_r.a_src;
	assign overdischarge_limit = state_r.a_ovdis;
	assign overcharge_limit = state_r.a_ovch;
	assign cold_limit_value = state_r.a_cold;
	assign hot_limit_value = state_r.a_hot;
	assign hold_up_enable = state_r.a_pwr[harvester_cfg_pkg::PWR_HOLD];
	assign high_power_enable = state_r.a_pwr[harvester_cfg_pkg::PWR_HIGH];
	assign thermal_watch_enable = state_r.a_pwr[harvester_cfg_pkg::PWR_THERM];
	assign charge_inhibit = state_r.a_pwr[harvester_cfg_pkg::PWR_INHIBIT];
	assign sleep_enable = state_r.a_slp[0];
	assign sleep_threshold = state_r.a_slp[3:1];
	assign power_meter_enable = state_r.a_meter;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_update_req;
		reg_wr && state_r.ptr == harvester_cfg_pkg::OFS_CTRL && state_r.sh[0] && !state_r.busy;
	endsequence
	sequence s_busy_window;
		state_r.busy [*4] ##1 !state_r.busy;
	endsequence

	a_busy_window:
	assert property (s_update_req |=> s_busy_window)
		else $error("busy flag not high for the load time");
	a_load_applies:
	assert property ($fell(state_r.busy) |-> state_r.serial
		&& state_r.flags[harvester_cfg_pkg::EV_READY]
		&& state_r.a_src == $past(state_r.src))
		else $error("load did not apply configuration");
	a_serial_sticky:
	assert property (state_r.serial |=> state_r.serial
		&& $stable(state_r.a_pwr[harvester_cfg_pkg::PWR_INHIBIT]) || $past(state_r.busy))
		else $error("serial configuration lost or pins followed");
	a_irq_enabled:
	assert property (state_r.flags[harvester_cfg_pkg::EV_READY] && state_r.en[0] |-> irq)
		else $error("enabled flag set without interrupt");
	a_irq_masked:
	assert property (state_r.flags == 7'h40 |-> !irq)
		else $error("meter error flag raised interrupt");
	a_flag_set_wins:
	assert property (meter_done_event |=> state_r.flags[harvester_cfg_pkg::EV_DONE])
		else $error("meter done event lost");
	a_reset_values:
	assert property ($rose(rst_b) |-> state_r.src == 7'h77 && state_r.ovdis == 6'h2D
		&& state_r.ovch == 6'h33 && state_r.cold == 8'h8F && state_r.hot == 8'h2F
		&& state_r.power_control == 4'h7 && state_r.slp == 4'h1 && state_r.en == 6'h01)
		else $error("register reset value wrong");
	a_reserved_sink_noeffect:
	assert property (reg_wr && state_r.ptr == harvester_cfg_pkg::OFS_RESERVED_SINK |=>
		$stable(state_r.src)
		&& $stable(state_r.power_control) && $stable(state_r.a_pwr) && !state_r.busy)
		else $error("reserved write changed behaviour");
	a_addr_match:
	assert property (state_r.st == ADDR && $past(state_r.st) == ADDR ##1
		state_r.st == ACK_ADDR |-> $past(state_r.sh[7:1]) == harvester_cfg_pkg::DEV_ADDR)
		else $error("acknowledged a foreign address");
	a_strap_capture:
	assert property (state_r.boot_cnt == 2'h2 |=> state_r.src_code == $past(state_r.src_s)
		&& state_r.sto_code == $past(state_r.sto_s))
		else $error("straps not captured at startup");

endmodule // harvester_config_registers
`default_nettype wire

// ### hw/strap_decoder.sv
// Decoder of strap codes into voltages in units of 10 mV
`timescale 1ns/1ps
`default_nettype none
module strap_decoder (
	input wire logic core_clk,
	input wire logic rst_b,
	strap_if.decoder sif
);
	typedef struct packed {
		logic [6:0] src_cv;
		logic [8:0] ovch_cv;
		logic [8:0] ovdis_cv;
	} dec_t;

	dec_t state_r;
	dec_t state_nxt;

	// Source target; top code bit has no listed setting and is ignored
	function automatic logic [6:0] src_level(input logic [4:0] c);
		logic [6:0] k;
		k = {2'h0, c};
		if (k < 7'h06) begin
			src_level = 7'h0C;
		end else if (k < 7'h12) begin
			src_level = 7'(7'h0C + 7'h03 * ((k - 7'h06) >> 1) + {6'h00, k[0]});
		end else begin
			src_level = 7'(7'h1E + 7'h03 * (k - 7'h12));
		end
	endfunction

	// Threshold pair per storage code
	always_comb begin
		state_nxt.src_cv = src_level(sif.src_code[4:0]);
		unique case (sif.sto_code)
			3'h0: {state_nxt.ovch_cv, state_nxt.ovdis_cv} = {9'h1C2, 9'h14A};
			3'h1: {state_nxt.ovch_cv, state_nxt.ovdis_cv} = {9'h190, 9'h118};
			3'h2: {state_nxt.ovch_cv, state_nxt.ovdis_cv} = {9'h16B, 9'h118};
			3'h3: {state_nxt.ovch_cv, state_nxt.ovdis_cv} = {9'h186, 9'h118};
			3'h4: {state_nxt.ovch_cv, state_nxt.ovdis_cv} = {9'h17C, 9'h0FA};
			3'h5: {state_nxt.ovch_cv, state_nxt.ovdis_cv} = {9'h186, 9'h12D};
			3'h6: {state_nxt.ovch_cv, state_nxt.ovdis_cv} = {9'h1B3, 9'h12D};
			3'h7: {state_nxt.ovch_cv, state_nxt.ovdis_cv} = {9'h19C, 9'h12D};
		endcase
		if (!rst_b) begin
			state_nxt = '0;
		end
	end

	// Registered outputs
	always_ff @(posedge core_clk) begin
		state_r <= state_nxt;
	end

	assign sif.src_cv = state_r.src_cv;
	assign sif.ovch_cv = state_r.ovch_cv;
	assign sif.ovdis_cv = state_r.ovdis_cv;

endmodule // strap_decoder
`default_nettype wire

// ### hw/strap_if.sv
// Strap codes and their decoded targets between core and decoder
`timescale 1ns/1ps
`default_nettype none
interface strap_if;
	logic [5:0] src_code;
	logic [2:0] sto_code;
	logic [6:0] src_cv;
	logic [8:0] ovch_cv;
	logic [8:0] ovdis_cv;
	modport core (output src_code, output sto_code, input src_cv, input ovch_cv,
		input ovdis_cv);
	modport decoder (input src_code, input sto_code, output src_cv, output ovch_cv,
		output ovdis_cv);
endinterface // strap_if
`default_nettype wire

// ### verif/harvester_config_registers_test.sv
// Self-checking bench of the harvester configuration register bank
`timescale 1ns/1ps
`default_nettype none
module harvester_config_registers_test;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hold_up_input = 1'b1;
	logic inh = 1'b0;
	logic [39:0] meas = 40'h1234563CC3;
	logic charging_pin = 1'b1;
	logic done_ev = 1'b0;
	logic err_ev = 1'b0;
	logic [3:0] cond = 4'h0;
	logic [7:0] rb [20];
	int n_mismatch = 0;
	int n_compared = 0;
	wire logic scl, host_rel, sda, oe_b, sda_out, irq, cfg_on, hold_en, inh_en, pm_en;
	wire logic [6:0] src_val, s_src;
	wire logic [8:0] s_ovch, s_ovdis;
	localparam logic [7:0] EXP [20] = '{8'h01, 8'h77, 8'h2D, 8'h33, 8'h8F, 8'h2F, 8'h07,
		8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h40, 8'h56, 8'h34, 8'h12, 8'h3C, 8'hC3, 8'h00};
	// Open-drain data line with pull-up
	assign sda = host_rel & (oe_b | sda_out);
	always #4 core_clk = ~core_clk;
	// Part id value is arbitrary
	harvester_config_registers #(.VERSION_ID(8'h01), .PART_ID(40'h4142434445))
	harvester_config_registers_i (
		.core_clk(core_clk), .rst_b(rst_b), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_b(oe_b), .irq(irq), .source_level_strap(6'h3F), .storage_threshold_strap(3'h7),
		.charge_inhibit_input(inh), .hold_up_input(hold_up_input), .condition_pins(cond),
		.charging_pin(charging_pin), .meter_done_event(done_ev), .meter_error_event(err_ev),
		.meter_data(meas[39:16]), .temperature_data(meas[15:8]), .storage_data(meas[7:0]),
		.serial_cfg_active(cfg_on), .strap_src_cv(s_src), .strap_ovch_cv(s_ovch),
		.strap_ovdis_cv(s_ovdis), .source_regulation_value(src_val), .overdischarge_limit(),
		.overcharge_limit(), .cold_limit_value(), .hot_limit_value(), .hold_up_enable(hold_en),
		.high_power_enable(), .thermal_watch_enable(), .charge_inhibit(inh_en), .sleep_enable(),
		.sleep_threshold(), .power_meter_enable(pm_en));
	i2c_host_model i2c_host_model_i (.scl(scl), .sda_rel(host_rel), .sda(sda));
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Write one byte at a pointer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic n;
		i2c_host_model_i.start();
		i2c_host_model_i.put({harvester_cfg_pkg::DEV_ADDR, 1'b0}, n);
		i2c_host_model_i.put(a, n);
		i2c_host_model_i.put(d, n);
		i2c_host_model_i.stop();
		chk("write ack", 9'h0, {8'h0, n});
	endtask
	// Burst read through a repeated start
	task automatic rd(input logic [7:0] a, input int cnt);
		logic n;
		i2c_host_model_i.start();
		i2c_host_model_i.put({harvester_cfg_pkg::DEV_ADDR, 1'b0}, n);
		i2c_host_model_i.put(a, n);
		i2c_host_model_i.start();
		i2c_host_model_i.put({harvester_cfg_pkg::DEV_ADDR, 1'b1}, n);
		for (int i = 0; i < cnt; i++) i2c_host_model_i.get(i == cnt - 1, rb[i]);
		i2c_host_model_i.stop();
	endtask
	// Strap decode and every reset value; reserved place skipped
	task automatic t_reset();
		chk("strap src", 9'h045, {2'h0, s_src});
		chk("strap ovch", 9'h19C, s_ovch);
		chk("strap ovdis", 9'h12D, s_ovdis);
		rd(8'h00, 20);
		for (int i = 0; i < 20; i++)
			if (i != 8) chk("reg", {1'b0, EXP[i]}, {1'b0, rb[i]});
	endtask
	// Serial values stay idle until the load request
	task automatic t_load();
		@(posedge core_clk) #1 hold_up_input = 1'b0;
		inh = 1'b1;
		wr(8'h01, 8'h23);
		wr(8'h0A, 8'h7F);
		wr(8'h08, 8'h05);
		wr(8'h09, 8'h03);
		rd(8'h08, 3);
		chk("reserved", 9'h05, {1'b0, rb[0]});
		chk("meter ctl", 9'h03, {1'b0, rb[1]});
		chk("enables", 9'h3F, {1'b0, rb[2]});
		chk("src before", 9'h77, {2'h0, src_val});
		chk("hold pin", 9'h0, {8'h0, hold_en});
		chk("inhibit pin", 9'h1, {8'h0, inh_en});
		wr(8'h0B, 8'h01);
		for (int i = 0; i < 50 && cfg_on !== 1'b1; i++) @(posedge core_clk);
		chk("src after", 9'h23, {2'h0, src_val});
		chk("hold default", 9'h1, {8'h0, hold_en});
		chk("inhibit default", 9'h0, {8'h0, inh_en});
		chk("meter on", 9'h1, {8'h0, pm_en});
		chk("irq ready", 9'h1, {8'h0, irq});
		rd(8'h0C, 1);
		chk("ready flag", 9'h01, {1'b0, rb[0]});
		chk("irq clear", 9'h0, {8'h0, irq});
	endtask
	// Events set flags; the error enable can never be set
	task automatic t_event();
		@(posedge core_clk) #1 done_ev = 1'b1;
		cond = 4'h1;
		charging_pin = 1'b0;
		@(posedge core_clk) #1 done_ev = 1'b0;
		repeat (6) @(posedge core_clk);
		chk("irq events", 9'h1, {8'h0, irq});
		rd(8'h0C, 2);
		chk("flags", 9'h22, {1'b0, rb[0]});
		chk("status", 9'h02, {1'b0, rb[1]});
		@(posedge core_clk) #1 err_ev = 1'b1;
		@(posedge core_clk) #1 err_ev = 1'b0;
		repeat (2) @(posedge core_clk);
		chk("irq masked", 9'h0, {8'h0, irq});
		rd(8'h0C, 1);
		chk("error flag", 9'h40, {1'b0, rb[0]});
	endtask
	// Foreign address refused, then the part id bytes
	task automatic t_addr();
		logic n;
		i2c_host_model_i.start();
		i2c_host_model_i.put(8'h84, n);
		i2c_host_model_i.stop();
		chk("foreign nack", 9'h1, {8'h0, n});
		rd(8'hE0, 5);
		for (int i = 0; i < 5; i++) chk("part id", {1'b0, 8'h41 + 8'(i)}, {1'b0, rb[i]});
	endtask
	task automatic wrap_up();
		$display("Compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		#1 rst_b = 1'b1;
		repeat (8) @(posedge core_clk);
		t_reset();
		t_load();
		t_event();
		t_addr();
		wrap_up();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#500us;
		n_mismatch++;
		wrap_up();
	end
endmodule // harvester_config_registers_test
`default_nettype wire

// ### verif/i2c_host_model.sv
// Host serial controller model driving the clock and data lines
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
	output logic scl,
	output logic sda_rel,
	input wire logic sda
);
	// Quarter of the 125 ns link period; clock rests high between frames
	localparam realtime Q = 31.25;
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// Start or repeated start, clock left low
	task automatic start();
		sda_rel = 1'b1;
		#Q scl = 1'b1;
		#Q sda_rel = 1'b0;
		#Q scl = 1'b0;
	endtask
	// Stop, then the line is left to its pull-up
	task automatic stop();
		sda_rel = 1'b0;
		#Q scl = 1'b1;
		#Q sda_rel = 1'b1;
		#Q;
	endtask
	// Data moves only while the clock is low, read at the rise
	task automatic bit_io(input logic b, output logic s);
		#Q sda_rel = b;
		#Q scl = 1'b1;
		s = sda;
		#(2 * Q) scl = 1'b0;
	endtask
	// Byte out msb first; returns the acknowledge level
	task automatic put(input logic [7:0] d, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, nack);
	endtask
	// Byte in; the last byte is not acknowledged
	task automatic get(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, s);
	endtask
endmodule // i2c_host_model
`default_nettype wire
